// File: pkg/exec_pkg.sv
// Shared constants, encodings and types for the subtract, swap and exclusive-OR execution slice.
package exec_pkg;

  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;

  // Instruction encodings, compared against the top bits of the instruction word; the sleep word against all 14 bits, the direction selects against the low 3.
  localparam logic [4:0] SUBL_PAT = 5'h1e;
  localparam logic [5:0] XORL_PAT = 6'h3a;
  localparam logic [5:0] SUBF_PAT = 6'h02;
  localparam logic [5:0] SWAP_PAT = 6'h0e;
  localparam logic [5:0] XORF_PAT = 6'h06;
  localparam logic [10:0] DIRLD_PAT = 11'h00c;
  localparam logic [13:0] SLEEP_WORD = 14'h0063;
  localparam logic [2:0] DIR_SEL_MIN = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX = 3'h7;
  localparam int DEST_BIT = 7;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] STATUS_OFS = 5'h04;
  localparam logic [4:0] ACC_OFS = 5'h08;
  localparam logic [4:0] DIR5_OFS = 5'h0c;
  localparam logic [4:0] DIR6_OFS = 5'h10;
  localparam logic [4:0] DIR7_OFS = 5'h14;

  // Control register fields.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;

  // Status register fields.
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PWRDN_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_SLEEP_BIT = 5;
  localparam int ST_UNSUP_BIT = 6;

  // Reset values.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic RUN_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b1;
  localparam logic TO_RST = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE, OP_SUBL, OP_SUBF, OP_SWAP, OP_DIRLD, OP_XORL, OP_XORF, OP_SLEEP
  } op_t;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

endpackage : exec_pkg

// File: hw/instr_decode.sv
// Combinational decoder from a 14-bit instruction word to an operation and its operand fields.
`timescale 1ns/1ps
`default_nettype none
module instr_decode
  import exec_pkg::*;
(
  input wire logic [exec_pkg::WORD_W-1:0] word,
  output exec_pkg::op_t op,
  output logic dest_file,
  output logic [exec_pkg::FADDR_W-1:0] file_addr,
  output logic [exec_pkg::DATA_W-1:0] literal,
  output logic [1:0] dir_index
);
  import exec_pkg::*;

  logic [2:0] dir_sel;

  always_comb begin
    dest_file = word[DEST_BIT];
    file_addr = word[FADDR_W-1:0];
    literal = word[DATA_W-1:0];
    dir_sel = word[2:0];
    dir_index = 2'(dir_sel - DIR_SEL_MIN);
    if (word[13:9] == SUBL_PAT) begin
      op = OP_SUBL;
    end else if (word[13:8] == XORL_PAT) begin
      op = OP_XORL;
    end else if (word[13:8] == SUBF_PAT) begin
      op = OP_SUBF;
    end else if (word[13:8] == SWAP_PAT) begin
      op = OP_SWAP;
    end else if (word[13:8] == XORF_PAT) begin
      op = OP_XORF;
    end else if (word == SLEEP_WORD) begin
      op = OP_SLEEP;
    end else if (word[13:3] == DIRLD_PAT && dir_sel >= DIR_SEL_MIN && dir_sel <= DIR_SEL_MAX) begin
      op = OP_DIRLD;
    end else begin
      op = OP_NONE;
    end
  end

endmodule : instr_decode
`default_nettype wire

// File: hw/exec_alu.sv
// Arithmetic and logic stage: subtract, nibble swap and exclusive-OR with their flag results.
`timescale 1ns/1ps
`default_nettype none
module exec_alu
  import exec_pkg::*;
(
  input wire exec_pkg::op_t op,
  input wire logic [exec_pkg::DATA_W-1:0] acc,
  input wire logic [exec_pkg::DATA_W-1:0] operand,
  output logic [exec_pkg::DATA_W-1:0] result,
  output logic carry,
  output logic digit_carry,
  output logic zero,
  output logic upd_carry,
  output logic upd_zero
);
  import exec_pkg::*;

  logic [DATA_W:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    // The ninth bit of the difference is the borrow out, so carry is its inverse.
    diff = {1'b0, operand} - {1'b0, acc};
    low_diff = {1'b0, operand[3:0]} - {1'b0, acc[3:0]};
    result = acc;
    carry = 1'b0;
    digit_carry = 1'b0;
    upd_carry = 1'b0;
    upd_zero = 1'b0;
    case (op)
      OP_SUBL, OP_SUBF: begin
        result = diff[DATA_W-1:0];
        carry = ~diff[DATA_W];
        digit_carry = ~low_diff[4];
        upd_carry = 1'b1;
        upd_zero = 1'b1;
      end
      OP_SWAP: begin
        result = {operand[3:0], operand[7:4]};
      end
      OP_XORL, OP_XORF: begin
        result = acc ^ operand;
        upd_zero = 1'b1;
      end
      default: begin
        result = acc;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule : exec_alu
`default_nettype wire

// File: hw/subtract_swap_xor_exec.sv
// Quarter-cycle sequencer, working state and Avalon-MM register slave of the execution slice.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module subtract_swap_xor_exec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [exec_pkg::WORD_W-1:0] instr_word,
  output logic file_rd_en,
  output logic [exec_pkg::FADDR_W-1:0] file_rd_addr,
  input wire logic [exec_pkg::DATA_W-1:0] file_rd_data,
  output logic file_wr_en,
  output logic [exec_pkg::FADDR_W-1:0] file_wr_addr,
  output logic [exec_pkg::DATA_W-1:0] file_wr_data,
  output logic wdt_clear,
  output logic osc_stop,
  output logic [exec_pkg::DATA_W-1:0] dir5_out,
  output logic [exec_pkg::DATA_W-1:0] dir6_out,
  output logic [exec_pkg::DATA_W-1:0] dir7_out,
  input wire logic [exec_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [exec_pkg::BUS_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [exec_pkg::BUS_DW-1:0] avs_readdata,
  output logic avs_waitrequest
);
  import exec_pkg::*;

  phase_t phase_q, phase_d;
  op_t op_q, op_d;
  logic dest_file_q, dest_file_d;
  logic [FADDR_W-1:0] faddr_q, faddr_d;
  logic [DATA_W-1:0] literal_q, literal_d;
  logic [1:0] dir_idx_q, dir_idx_d;
  logic [DATA_W-1:0] operand_q, operand_d;
  logic [DATA_W-1:0] result_q, result_d;
  logic res_c_q, res_c_d;
  logic res_dc_q, res_dc_d;
  logic res_z_q, res_z_d;
  logic upd_c_q, upd_c_d;
  logic upd_z_q, upd_z_d;

  logic [DATA_W-1:0] acc_q, acc_d;
  logic c_q, c_d;
  logic dc_q, dc_d;
  logic z_q, z_d;
  logic pwrdn_q, pwrdn_d;
  logic to_q, to_d;
  logic sleep_q, sleep_d;
  logic unsup_q, unsup_d;
  logic run_q, run_d;
  logic [DATA_W-1:0] dir_q [3];
  logic [DATA_W-1:0] dir_d [3];

  logic ack_q, ack_d;
  logic [BUS_DW-1:0] rdata_q, rdata_d;

  op_t dec_op;
  logic dec_dest;
  logic [FADDR_W-1:0] dec_faddr;
  logic [DATA_W-1:0] dec_literal;
  logic [1:0] dec_dir_idx;
  logic [DATA_W-1:0] alu_result;
  logic alu_c, alu_dc, alu_z, alu_upd_c, alu_upd_z;

  logic file_op;
  logic acc_write;
  logic bus_wr;
  logic bus_lane0;

  instr_decode u_decode (
    .word(instr_word),
    .op(dec_op),
    .dest_file(dec_dest),
    .file_addr(dec_faddr),
    .literal(dec_literal),
    .dir_index(dec_dir_idx)
  );

  exec_alu u_alu (
    .op(op_q),
    .acc(acc_q),
    .operand(operand_q),
    .result(alu_result),
    .carry(alu_c),
    .digit_carry(alu_dc),
    .zero(alu_z),
    .upd_carry(alu_upd_c),
    .upd_zero(alu_upd_z)
  );

  // A request is held one cycle in wait so that read data come from a flip-flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign bus_wr = avs_write & ack_q;
  assign bus_lane0 = avs_byteenable[0];

  assign file_op = (op_q == OP_SUBF) || (op_q == OP_SWAP) || (op_q == OP_XORF);
  assign instr_ready = (phase_q == PH_Q1) && run_q && !sleep_q;
  assign file_rd_en = (phase_q == PH_Q2) && file_op;
  assign file_rd_addr = faddr_q;
  assign file_wr_addr = faddr_q;
  assign file_wr_data = result_q;
  assign file_wr_en = (phase_q == PH_Q4) && file_op && dest_file_q;
  assign wdt_clear = (phase_q == PH_Q4) && (op_q == OP_SLEEP);
  assign osc_stop = sleep_q;
  assign acc_write = (phase_q == PH_Q4) &&
                     ((op_q == OP_SUBL) || (op_q == OP_XORL) || (file_op && !dest_file_q));
  assign dir5_out = dir_q[0];
  assign dir6_out = dir_q[1];
  assign dir7_out = dir_q[2];

  // Quarter-cycle sequencer and pipeline registers.
  always_comb begin
    phase_d = phase_q;
    op_d = op_q;
    dest_file_d = dest_file_q;
    faddr_d = faddr_q;
    literal_d = literal_q;
    dir_idx_d = dir_idx_q;
    operand_d = operand_q;
    result_d = result_q;
    res_c_d = res_c_q;
    res_dc_d = res_dc_q;
    res_z_d = res_z_q;
    upd_c_d = upd_c_q;
    upd_z_d = upd_z_q;
    case (phase_q)
      PH_Q1: begin
        if (instr_ready && instr_valid) begin
          op_d = dec_op;
          dest_file_d = dec_dest;
          faddr_d = dec_faddr;
          literal_d = dec_literal;
          dir_idx_d = dec_dir_idx;
          phase_d = PH_Q2;
        end
      end
      PH_Q2: begin
        if (file_op) begin
          operand_d = file_rd_data;
        end else begin
          operand_d = literal_q;
        end
        phase_d = PH_Q3;
      end
      PH_Q3: begin
        result_d = alu_result;
        res_c_d = alu_c;
        res_dc_d = alu_dc;
        res_z_d = alu_z;
        upd_c_d = alu_upd_c;
        upd_z_d = alu_upd_z;
        phase_d = PH_Q4;
      end
      default: begin
        phase_d = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_Q1;
      op_q <= OP_NONE;
      dest_file_q <= 1'b0;
      faddr_q <= 7'h00;
      literal_q <= 8'h00;
      dir_idx_q <= 2'h0;
      operand_q <= 8'h00;
      result_q <= 8'h00;
      res_c_q <= 1'b0;
      res_dc_q <= 1'b0;
      res_z_q <= 1'b0;
      upd_c_q <= 1'b0;
      upd_z_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      op_q <= op_d;
      dest_file_q <= dest_file_d;
      faddr_q <= faddr_d;
      literal_q <= literal_d;
      dir_idx_q <= dir_idx_d;
      operand_q <= operand_d;
      result_q <= result_d;
      res_c_q <= res_c_d;
      res_dc_q <= res_dc_d;
      res_z_q <= res_z_d;
      upd_c_q <= upd_c_d;
      upd_z_q <= upd_z_d;
    end
  end

  // Architectural state and the register slave; the core's Q4 write wins over software.
  always_comb begin
    acc_d = acc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    pwrdn_d = pwrdn_q;
    to_d = to_q;
    sleep_d = sleep_q;
    unsup_d = unsup_q;
    run_d = run_q;
    for (int i = 0; i < 3; i++) begin
      dir_d[i] = dir_q[i];
    end
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;

    if (avs_read && !ack_q) begin
      if (avs_address == CTRL_OFS) begin
        rdata_d = 32'h0;
        rdata_d[CTRL_RUN_BIT] = run_q;
      end else if (avs_address == STATUS_OFS) begin
        rdata_d = 32'h0;
        rdata_d[ST_C_BIT] = c_q;
        rdata_d[ST_DC_BIT] = dc_q;
        rdata_d[ST_Z_BIT] = z_q;
        rdata_d[ST_PWRDN_BIT] = pwrdn_q;
        rdata_d[ST_TO_BIT] = to_q;
        rdata_d[ST_SLEEP_BIT] = sleep_q;
        rdata_d[ST_UNSUP_BIT] = unsup_q;
      end else if (avs_address == ACC_OFS) begin
        rdata_d = {24'h0, acc_q};
      end else if (avs_address == DIR5_OFS) begin
        rdata_d = {24'h0, dir_q[0]};
      end else if (avs_address == DIR6_OFS) begin
        rdata_d = {24'h0, dir_q[1]};
      end else if (avs_address == DIR7_OFS) begin
        rdata_d = {24'h0, dir_q[2]};
      end else begin
        rdata_d = 32'h0;
      end
    end

    if (bus_wr && bus_lane0) begin
      if (avs_address == CTRL_OFS) begin
        run_d = avs_writedata[CTRL_RUN_BIT];
        if (avs_writedata[CTRL_WAKE_BIT]) begin
          sleep_d = 1'b0;
        end
      end else if (avs_address == STATUS_OFS) begin
        c_d = avs_writedata[ST_C_BIT];
        dc_d = avs_writedata[ST_DC_BIT];
        z_d = avs_writedata[ST_Z_BIT];
        if (avs_writedata[ST_UNSUP_BIT]) begin
          unsup_d = 1'b0;
        end
      end else if (avs_address == ACC_OFS) begin
        acc_d = avs_writedata[DATA_W-1:0];
      end else if (avs_address == DIR5_OFS) begin
        dir_d[0] = avs_writedata[DATA_W-1:0];
      end else if (avs_address == DIR6_OFS) begin
        dir_d[1] = avs_writedata[DATA_W-1:0];
      end else if (avs_address == DIR7_OFS) begin
        dir_d[2] = avs_writedata[DATA_W-1:0];
      end
    end

    if (phase_q == PH_Q4) begin
      if (acc_write) begin
        acc_d = result_q;
      end
      // Swap and direction load leave the flags alone, exclusive-OR touches only zero.
      if (upd_c_q) begin
        c_d = res_c_q;
        dc_d = res_dc_q;
      end
      if (upd_z_q) begin
        z_d = res_z_q;
      end
      if (op_q == OP_DIRLD) begin
        dir_d[dir_idx_q] = acc_q;
      end
      if (op_q == OP_SLEEP) begin
        to_d = 1'b1;
        pwrdn_d = 1'b0;
        sleep_d = 1'b1;
      end
      if (op_q == OP_NONE) begin
        unsup_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      pwrdn_q <= PWRDN_RST;
      to_q <= TO_RST;
      sleep_q <= 1'b0;
      unsup_q <= 1'b0;
      run_q <= RUN_RST;
      for (int i = 0; i < 3; i++) begin
        dir_q[i] <= DIR_RST;
      end
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      pwrdn_q <= pwrdn_d;
      to_q <= to_d;
      sleep_q <= sleep_d;
      unsup_q <= unsup_d;
      run_q <= run_d;
      for (int i = 0; i < 3; i++) begin
        dir_q[i] <= dir_d[i];
      end
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule : subtract_swap_xor_exec
`default_nettype wire

// File: dv/exec_sva.sv
// Concurrent checks on the ports of the execution slice.
`timescale 1ns/1ps
`default_nettype none
module exec_sva
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [13:0] instr_word,
  input wire logic file_rd_en,
  input wire logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  input wire logic wdt_clear,
  input wire logic osc_stop,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  logic take;
  logic fop;
  logic [13:0] word_q;
  logic [7:0] cap_q;
  assign take = instr_valid && instr_ready;
  assign fop = instr_word[13:8] inside {SUBF_PAT, SWAP_PAT, XORF_PAT};
  // The word and the Q2 read byte are held so later quarters can be tied to them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= '0;
      cap_q <= '0;
    end else begin
      if (take) word_q <= instr_word;
      if (file_rd_en) cap_q <= file_rd_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_in_q2_a: assert property (take && fop |=> file_rd_en ##1 !file_rd_en)
    else $error("file read not in second quarter");
  ready_gap_a: assert property (take |=> !instr_ready [*3])
    else $error("instruction taken before four quarters");
  wr_in_q4_a: assert property (take && fop && instr_word[DEST_BIT]
    |-> ##3 file_wr_en && file_wr_addr == word_q[6:0])
    else $error("file write missing in fourth quarter");
  no_wr_acc_a: assert property (take && fop && !instr_word[DEST_BIT] |-> ##3 !file_wr_en)
    else $error("file written for accumulator destination");
  swap_data_a: assert property (take && instr_word[13:8] == SWAP_PAT && instr_word[DEST_BIT]
    |-> ##3 file_wr_data == {cap_q[3:0], cap_q[7:4]})
    else $error("nibble swap data wrong");
  lit_quiet_a: assert property (take && instr_word[13:12] == 2'b11 |=> (!file_rd_en && !file_wr_en) [*3])
    else $error("literal op touched file");
  sleep_seq_a: assert property (take && instr_word == SLEEP_WORD
    |-> !wdt_clear ##3 wdt_clear ##1 (osc_stop && !instr_ready))
    else $error("sleep sequence wrong");
  wdt_cause_a: assert property (wdt_clear |-> word_q == SLEEP_WORD && !$past(wdt_clear))
    else $error("watchdog clear without sleep");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  asleep_idle_a: assert property (osc_stop |-> !instr_ready)
    else $error("instruction offered while asleep");
endmodule : exec_sva
bind subtract_swap_xor_exec exec_sva i_sva (.clk, .rst_n, .instr_valid, .instr_ready, .instr_word,
  .file_rd_en, .file_rd_data, .file_wr_en, .file_wr_addr, .file_wr_data, .wdt_clear, .osc_stop,
  .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// File: dv/file_reg_model.sv
// Data register file seen by the execution slice.
`timescale 1ns/1ps
`default_nettype none
module file_reg_model (
  input wire logic clk,
  input wire logic file_rd_en,
  input wire logic [6:0] file_rd_addr,
  output logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [6:0] file_wr_addr,
  input wire logic [7:0] file_wr_data
);
  logic [7:0] mem [128];
  logic [7:0] last_q = 8'h00;
  // Outside the read strobe the bus shows garbage, so a late sample cannot pass.
  assign file_rd_data = file_rd_en ? mem[file_rd_addr] : ~last_q;
  always @(posedge clk) begin
    if (file_rd_en) last_q <= mem[file_rd_addr];
    if (file_wr_en) mem[file_wr_addr] <= file_wr_data;
  end
endmodule : file_reg_model
`default_nettype wire

// File: dv/tb_subtract_swap_xor_exec.sv
// Self-checking bench of the execution slice.
`timescale 1ns/1ps
`default_nettype none
module tb_subtract_swap_xor_exec;
  import exec_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic instr_valid = 0;
  logic [13:0] instr_word = '0;
  logic [4:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic instr_ready, file_rd_en, file_wr_en, wdt_clear, osc_stop, avs_waitrequest;
  logic [6:0] file_rd_addr, file_wr_addr;
  logic [7:0] file_rd_data, file_wr_data, dir5_out, dir6_out, dir7_out;
  logic [31:0] avs_readdata;
  int miscompares = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  subtract_swap_xor_exec i_dut (.clk, .rst_n, .instr_valid, .instr_ready, .instr_word, .file_rd_en,
    .file_rd_addr, .file_rd_data, .file_wr_en, .file_wr_addr, .file_wr_data, .wdt_clear, .osc_stop,
    .dir5_out, .dir6_out, .dir7_out, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  file_reg_model i_mem (.clk, .file_rd_en, .file_rd_addr, .file_rd_data, .file_wr_en,
    .file_wr_addr, .file_wr_data);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    // Waitrequest and read data are looked at on the rising edge, before the slave's flops move.
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (n >= 20) miscompares++;
  endtask : bus
  task automatic exec(input logic [13:0] w);
    int n;
    n = 0;
    @(posedge clk);
    instr_valid <= 1;
    instr_word <= w;
    do begin
      @(posedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 20);
    instr_valid <= 0;
    instr_word <= 14'($urandom);
    // The take edge is followed by Q2, Q3 and Q4; one spare edge lets the Q4 write settle.
    repeat (4) @(posedge clk);
    if (n >= 20) miscompares++;
  endtask : exec
  // Returns {flags Z DC C, result} for op 0 sub-lit, 1 xor-lit, 2 sub-file, 3 xor-file, 4 swap.
  function automatic logic [10:0] expect_of(int op, logic [7:0] w, k, f, logic [2:0] st);
    logic [7:0] o;
    logic [7:0] r;
    o = (op < 2) ? k : f;
    if (op == 0 || op == 2) return {(o - w) == 8'h00, o[3:0] >= w[3:0], o >= w, 8'(o - w)};
    if (op == 4) return {st, f[3:0], f[7:4]};
    r = o ^ w;
    return {r == 8'h00, st[1:0], r};
  endfunction : expect_of
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    logic [31:0] q;
    logic [7:0] w, k, f;
    logic [7:0] dx [3];
    logic [6:0] a;
    logic [2:0] st;
    logic [10:0] e;
    logic [13:0] word;
    logic d;
    logic tof;
    int op;
    void'($urandom(48092));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    bus(0, STATUS_OFS, 0, q);
    chk("status", q, 32'h18);
    bus(0, ACC_OFS, 0, q);
    chk("acc", q, 0);
    bus(0, 5'h1c, 0, q);
    chk("unmapped", q, 0);
    chk("dirs", {dir5_out, dir6_out, dir7_out}, 24'hffffff);
    bus(1, CTRL_OFS, 32'h0, q);
    @(negedge clk);
    chk("halted", instr_ready, 0);
    bus(1, CTRL_OFS, 32'h1, q);
    avs_byteenable <= 4'he;
    bus(1, ACC_OFS, 32'h5a, q);
    avs_byteenable <= 4'hf;
    bus(0, ACC_OFS, 0, q);
    chk("lane", q, 0);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      op = (i < 3) ? 0 : $urandom_range(4);
      w = (i < 3) ? 8'(i + 1) : 8'($urandom);
      k = (i < 3) ? 8'h02 : 8'($urandom);
      f = 8'($urandom);
      a = 7'($urandom);
      d = 1'($urandom);
      st = 3'($urandom);
      i_mem.mem[a] = f;
      bus(1, STATUS_OFS, {29'h0, st}, q);
      bus(1, ACC_OFS, {24'h0, w}, q);
      case (op)
        0: word = {SUBL_PAT, d, k};
        1: word = {XORL_PAT, k};
        2: word = {SUBF_PAT, d, a};
        3: word = {XORF_PAT, d, a};
        default: word = {SWAP_PAT, d, a};
      endcase
      exec(word);
      e = expect_of(op, w, k, f, st);
      tof = (op >= 2) && d;
      bus(0, ACC_OFS, 0, q);
      chk("acc", q, {24'h0, tof ? w : e[7:0]});
      bus(0, STATUS_OFS, 0, q);
      chk("flags", q[2:0], e[10:8]);
      chk("file", i_mem.mem[a], tof ? e[7:0] : f);
    end
    $display("test arithmetic done");
    dx = '{8'hff, 8'hff, 8'hff};
    for (int s = 5; s <= 8; s++) begin
      w = 8'($urandom);
      bus(1, ACC_OFS, {24'h0, w}, q);
      exec({DIRLD_PAT, 3'(s)});
      if (s < 8) dx[s - 5] = w;
      chk("dirs", {dir5_out, dir6_out, dir7_out}, {dx[0], dx[1], dx[2]});
    end
    bus(0, STATUS_OFS, 0, q);
    chk("unsup", q[6], 1);
    $display("test direction done");
    exec(SLEEP_WORD);
    chk("asleep", {osc_stop, instr_ready}, 2'b10);
    bus(0, STATUS_OFS, 0, q);
    chk("sleep status", q[5:3], 3'b110);
    bus(1, CTRL_OFS, 32'h3, q);
    repeat (2) @(negedge clk);
    chk("wake", osc_stop, 0);
    $display("test sleep done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_subtract_swap_xor_exec
`default_nettype wire
